// >>> sscd_defines.svh
`ifndef SSCD_DEFINES_SVH
`define SSCD_DEFINES_SVH

// register offsets on the configuration port
`define SSCD_OFS_SETTLE_CH1 8'h11
`define SSCD_OFS_SETTLE_CH2 8'h12
`define SSCD_OFS_SETTLE_CH3 8'h13
`define SSCD_OFS_CLKDIV_CH0 8'h14
`define SSCD_OFS_CLKDIV_CH1 8'h15

// clock-divider field layout
`define SSCD_FIN_MSB 15
`define SSCD_FIN_LSB 12
`define SSCD_RSV_MSB 11
`define SSCD_RSV_LSB 10
`define SSCD_FREF_MSB 9
`define SSCD_FREF_LSB 0

// reset values
`define SSCD_RST_SETTLE 16'h0000
`define SSCD_RST_CLKDIV 16'h0000

// settle timing in divided reference cycles
`define SSCD_SETTLE_MIN_TICKS 20'h00020
`define SSCD_SETTLE_MULT_SHIFT 4

`endif

// >>> sscd_pkg.sv
package sscd_pkg;
    // settle sequencer states
    typedef enum logic [0:0] {
        SSCD_IDLE = 1'b0,
        SSCD_SETTLE = 1'b1
    } sscd_state_e;
    // channel number
    typedef logic [1:0] sscd_chan_t;
    // 16-bit register word
    typedef logic [15:0] sscd_word_t;
    // settle down-counter width
    typedef logic [19:0] sscd_settle_t;
endpackage

// >>> sscd_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the block and one of its event dividers
interface sscd_div_if;
    logic [9:0] div_val; // division ratio, zero treated as one
    logic event_in; // one event to count
    logic tick; // one pulse per div_val events
    modport divider (input div_val, input event_in, output tick);
    modport user (output div_val, output event_in, input tick);
endinterface
`default_nettype wire

// >>> sscd_event_div.sv
`timescale 1ns/1ps
`default_nettype none
// counts events and emits one registered pulse per ratio
module sscd_event_div (
    input wire logic clk_i,
    input wire logic rst_i,
    sscd_div_if.divider div
);
    logic [9:0] cnt; // events seen in this period
    logic last; // this event closes the period

    // ratio of zero is reserved and behaves as one
    assign last = ({1'b0, cnt} + 11'h001) >= {1'b0, div.div_val};

    // event counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 10'h000;
        end else if (div.event_in) begin
            cnt <= last ? 10'h000 : cnt + 10'h001;
        end
    end

    // registered output pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div.tick <= 1'b0;
        end else begin
            div.tick <= div.event_in & last;
        end
    end
endmodule
`default_nettype wire

// >>> sscd_settle_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
`include "sscd_defines.svh"
// Summary of operation
// - wait settle interval before each conversion
// - flag amplitude error if unsettled, when enabled
// - counts 0,1 give 32; else count*16
// - settle registers 16-bit RW, reset zero
// - sensor divider bits 15:12 divide sensor
// - reference divider bits 9:0 divide clock
// - channel 1 dividers share channel 0 layout
// - channel 1 reference from its divider
module sscd_settle_clkdiv
    import sscd_pkg::*;
#(
    parameter bit FOUR_CH = 1'b1 // channels 2 and 3 settle registers present
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic SENSOR_CH0_I,
    input wire logic SENSOR_CH1_I,
    output logic FIN_CH0_O,
    output logic FIN_CH1_O,
    output logic FREF_TICK_CH0_O,
    output logic FREF_TICK_CH1_O,
    input wire logic CH_START_I,
    input wire logic [1:0] CH_SEL_I,
    input wire logic AMP_SETTLED_I,
    input wire logic AMP_ERR_EN_I,
    output logic SETTLING_O,
    output logic [1:0] ACTIVE_CH_O,
    output logic CONV_START_O,
    output logic AMP_ERR_O
);
    // register storage
    sscd_word_t settle_count_ch1; // channel 1 settle count
    sscd_word_t settle_count_ch2; // channel 2 settle count
    sscd_word_t settle_count_ch3; // channel 3 settle count
    sscd_word_t clock_dividers_ch0; // channel 0 dividers
    sscd_word_t clock_dividers_ch1; // channel 1 dividers

    // sequencer state
    sscd_state_e state; // idle or settling
    sscd_chan_t active_ch; // channel being settled
    sscd_settle_t settle_left; // remaining reference ticks
    logic ref_tick_sel; // reference tick of active channel
    logic start_ok; // start request for a present channel
    logic sensor0_q; // previous sensor 0 level
    logic sensor1_q; // previous sensor 1 level

    // divider links
    sscd_div_if ref0_if ();
    sscd_div_if ref1_if ();
    sscd_div_if fin0_if ();
    sscd_div_if fin1_if ();

    // settle length in reference ticks
    function automatic sscd_settle_t settle_ticks(input sscd_word_t count);
        sscd_settle_t ticks;
        ticks = `SSCD_SETTLE_MIN_TICKS;
        if (count > 16'h0001) begin
            ticks = {count, 4'h0};
        end
        return ticks;
    endfunction

    // settle count register for a channel
    function automatic sscd_word_t settle_of(input sscd_chan_t ch,
                                             input sscd_word_t c1,
                                             input sscd_word_t c2,
                                             input sscd_word_t c3);
        sscd_word_t v;
        v = 16'h0000;
        unique case (ch)
            2'h0: v = 16'h0000; // channel 0 uses the minimum interval
            2'h1: v = c1;
            2'h2: v = c2;
            2'h3: v = c3;
        endcase
        return v;
    endfunction

    // settle count registers
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            settle_count_ch1 <= `SSCD_RST_SETTLE;
            settle_count_ch2 <= `SSCD_RST_SETTLE;
            settle_count_ch3 <= `SSCD_RST_SETTLE;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == `SSCD_OFS_SETTLE_CH1) begin
                settle_count_ch1 <= REG_WDATA_I;
            end
            // channels 2 and 3 only on the wide variant
            if (FOUR_CH && REG_ADDR_I == `SSCD_OFS_SETTLE_CH2) begin
                settle_count_ch2 <= REG_WDATA_I;
            end
            if (FOUR_CH && REG_ADDR_I == `SSCD_OFS_SETTLE_CH3) begin
                settle_count_ch3 <= REG_WDATA_I;
            end
        end
    end

    // clock divider registers, reserved bits stored as written
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clock_dividers_ch0 <= `SSCD_RST_CLKDIV;
            clock_dividers_ch1 <= `SSCD_RST_CLKDIV;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == `SSCD_OFS_CLKDIV_CH0) begin
                clock_dividers_ch0 <= REG_WDATA_I;
            end
            if (REG_ADDR_I == `SSCD_OFS_CLKDIV_CH1) begin
                clock_dividers_ch1 <= REG_WDATA_I;
            end
        end
    end

    // registered read data, unmapped reads zero
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 16'h0000;
        end else begin
            unique case (REG_ADDR_I)
                `SSCD_OFS_SETTLE_CH1: REG_RDATA_O <= settle_count_ch1;
                `SSCD_OFS_SETTLE_CH2: REG_RDATA_O <= FOUR_CH ? settle_count_ch2 : 16'h0000;
                `SSCD_OFS_SETTLE_CH3: REG_RDATA_O <= FOUR_CH ? settle_count_ch3 : 16'h0000;
                `SSCD_OFS_CLKDIV_CH0: REG_RDATA_O <= clock_dividers_ch0;
                `SSCD_OFS_CLKDIV_CH1: REG_RDATA_O <= clock_dividers_ch1;
                default: REG_RDATA_O <= 16'h0000;
            endcase
        end
    end

    // sensor edge history, starts high so a pin already high at reset is no edge
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sensor0_q <= 1'b1;
            sensor1_q <= 1'b1;
        end else begin
            sensor0_q <= SENSOR_CH0_I;
            sensor1_q <= SENSOR_CH1_I;
        end
    end

    assign ref0_if.div_val = clock_dividers_ch0[`SSCD_FREF_MSB:`SSCD_FREF_LSB];
    assign ref0_if.event_in = 1'b1;
    // channel 1 reference from its own field
    assign ref1_if.div_val = clock_dividers_ch1[`SSCD_FREF_MSB:`SSCD_FREF_LSB];
    assign ref1_if.event_in = 1'b1;

    // sensor dividers count rising sensor edges
    assign fin0_if.div_val = {6'h00, clock_dividers_ch0[`SSCD_FIN_MSB:`SSCD_FIN_LSB]};
    assign fin0_if.event_in = SENSOR_CH0_I & ~sensor0_q;
    assign fin1_if.div_val = {6'h00, clock_dividers_ch1[`SSCD_FIN_MSB:`SSCD_FIN_LSB]};
    assign fin1_if.event_in = SENSOR_CH1_I & ~sensor1_q;

    // divider instances
    sscd_event_div u_ref0 (.clk_i(CORE_CLK_I), .rst_i(RST_I), .div(ref0_if.divider));
    sscd_event_div u_ref1 (.clk_i(CORE_CLK_I), .rst_i(RST_I), .div(ref1_if.divider));
    sscd_event_div u_fin0 (.clk_i(CORE_CLK_I), .rst_i(RST_I), .div(fin0_if.divider));
    sscd_event_div u_fin1 (.clk_i(CORE_CLK_I), .rst_i(RST_I), .div(fin1_if.divider));

    // divided clocks out, registered inside the dividers
    assign FREF_TICK_CH0_O = ref0_if.tick;
    assign FREF_TICK_CH1_O = ref1_if.tick;
    assign FIN_CH0_O = fin0_if.tick;
    assign FIN_CH1_O = fin1_if.tick;

    // channels 2 and 3 refused on the narrow variant
    assign start_ok = CH_START_I && (FOUR_CH || !CH_SEL_I[1]);

    // channel 0 on its own reference, others on channel 1 reference
    assign ref_tick_sel = (active_ch == 2'h0) ? ref0_if.tick : ref1_if.tick;

    // settle sequencer and down-counter
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= SSCD_IDLE;
            active_ch <= 2'h0;
            settle_left <= 20'h00000;
        end else if (start_ok) begin
            state <= SSCD_SETTLE;
            active_ch <= CH_SEL_I;
            settle_left <= settle_ticks(settle_of(CH_SEL_I, settle_count_ch1,
                                                  settle_count_ch2, settle_count_ch3));
        end else begin
            unique case (state)
                SSCD_IDLE: begin
                    settle_left <= settle_left;
                end
                SSCD_SETTLE: begin
                    if (ref_tick_sel) begin
                        settle_left <= settle_left - 20'h00001;
                        if (settle_left == 20'h00001) begin
                            state <= SSCD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // conversion start and amplitude check pulses
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CONV_START_O <= 1'b0;
            AMP_ERR_O <= 1'b0;
        end else begin
            // start only once the interval has elapsed
            CONV_START_O <= !start_ok && state == SSCD_SETTLE && ref_tick_sel
                            && settle_left == 20'h00001;
            // unsettled amplitude at start, reporting enabled
            AMP_ERR_O <= !start_ok && state == SSCD_SETTLE && ref_tick_sel
                         && settle_left == 20'h00001 && !AMP_SETTLED_I && AMP_ERR_EN_I;
        end
    end

    // status outputs
    assign SETTLING_O = (state == SSCD_SETTLE);
    assign ACTIVE_CH_O = active_ch;
endmodule
`default_nettype wire

// >>> sscd_settle_clkdiv_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches settle sequencing and register read-back at the top ports
module sscd_settle_clkdiv_asserts #(
    parameter bit FOUR_CH = 1'b1 // mirrors the block's channel count
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic FIN_CH0_O,
    input wire logic CH_START_I,
    input wire logic [1:0] CH_SEL_I,
    input wire logic AMP_SETTLED_I,
    input wire logic AMP_ERR_EN_I,
    input wire logic SETTLING_O,
    input wire logic [1:0] ACTIVE_CH_O,
    input wire logic CONV_START_O,
    input wire logic AMP_ERR_O
);
    // address hits a present register
    wire logic mapped = REG_ADDR_I >= 8'h11 && REG_ADDR_I <= 8'h15
        && (FOUR_CH || REG_ADDR_I < 8'h12 || REG_ADDR_I > 8'h13);
    // start on a present channel
    wire logic start_ok = CH_START_I && (FOUR_CH || !CH_SEL_I[1]);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    conv_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
        else $error("conversion start longer than one cycle");
    settle_no_conv_a: assert property (SETTLING_O |-> !CONV_START_O)
        else $error("conversion start while settling");
    conv_after_settle_a: assert property (CONV_START_O |-> $past(SETTLING_O))
        else $error("conversion start without settle");
    err_with_conv_a: assert property (AMP_ERR_O |-> CONV_START_O)
        else $error("amplitude error outside conversion start");
    err_cause_a: assert property (CONV_START_O |->
        AMP_ERR_O == (!$past(AMP_SETTLED_I) && $past(AMP_ERR_EN_I)))
        else $error("amplitude error wrong");
    start_settle_a: assert property (start_ok |=>
        SETTLING_O && ACTIVE_CH_O == $past(CH_SEL_I))
        else $error("start did not load channel");
    unmapped_zero_a: assert property (!mapped |=> REG_RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    wr_readback_a: assert property (((REG_WR_I && mapped) ##1
        (!REG_WR_I && $stable(REG_ADDR_I))) |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("read-back differs from write");
    fin_pulse_a: assert property (FIN_CH0_O |=> !FIN_CH0_O)
        else $error("input divider pulse too long");
    cover property (AMP_ERR_O);
    cover property (CONV_START_O && !AMP_ERR_O);
    cover property (CH_START_I && SETTLING_O);
endmodule
bind sscd_settle_clkdiv sscd_settle_clkdiv_asserts #(.FOUR_CH(FOUR_CH)) chk_u (.*);
`default_nettype wire

// >>> sscd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sscd_defines.svh"
// host side of the configuration port, single-word accesses
module sscd_host_model (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    input wire logic [15:0] rdata_i
);
    // idle port at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
    end
    // one write cycle then one idle cycle, entered just after an edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (a == `SSCD_OFS_CLKDIV_CH0 || a == `SSCD_OFS_CLKDIV_CH1) begin
            d[11:10] = 2'h0;
            if (d[15:12] == 4'h0) d[15:12] = 4'h1;
            if (d[9:0] == 10'h000) d[9:0] = 10'h001;
        end
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #10;
        wr_o = 1'b0;
        wdata_o = ~d; // released data no longer shows the word
        @(posedge clk_i);
        #10;
    endtask
    // address for one edge, word taken after it
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr_o = a;
        @(posedge clk_i);
        #10;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> test_sscd_settle_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// register and settle sequencing tests
module test_sscd_settle_clkdiv;
    logic clk = 1'b0, rst = 1'b1, wr, start = 1'b0, ok = 1'b1, en = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [15:0] rdata_n; // read data of the two-channel variant
    logic [1:0] sel = 2'h0, act, sph = 2'h0;
    logic fin0, fin1, t0, t1, settling, conv, err;
    logic settling_n; // settling of the two-channel variant
    int n_mismatch = 0, check_count = 0, cyc = 0;
    sscd_host_model host_u (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rdata_i(rdata));
    sscd_settle_clkdiv dut_u (.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SENSOR_CH0_I(sph[1]),
        .SENSOR_CH1_I(~sph[1]), .FIN_CH0_O(fin0), .FIN_CH1_O(fin1), .FREF_TICK_CH0_O(t0),
        .FREF_TICK_CH1_O(t1), .CH_START_I(start), .CH_SEL_I(sel), .AMP_SETTLED_I(ok),
        .AMP_ERR_EN_I(en), .SETTLING_O(settling), .ACTIVE_CH_O(act),
        .CONV_START_O(conv), .AMP_ERR_O(err));
    // two-channel variant on the same stimulus
    sscd_settle_clkdiv #(.FOUR_CH(1'b0)) dut_n (.CORE_CLK_I(clk), .RST_I(rst),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata_n),
        .SENSOR_CH0_I(sph[1]), .SENSOR_CH1_I(~sph[1]), .FIN_CH0_O(), .FIN_CH1_O(),
        .FREF_TICK_CH0_O(), .FREF_TICK_CH1_O(), .CH_START_I(start), .CH_SEL_I(sel),
        .AMP_SETTLED_I(ok), .AMP_ERR_EN_I(en), .SETTLING_O(settling_n), .ACTIVE_CH_O(),
        .CONV_START_O(), .AMP_ERR_O());
    initial forever #50 clk = ~clk;
    // sensor at a quarter of the core clock, below the divider limit
    always @(posedge clk) #10 sph <= sph + 2'h1;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test;
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // cycles between two pulses of fin1, fin0, t0 or t1
    task automatic gap(input int s, input logic [15:0] exp);
        logic [15:0] n;
        logic [3:0] p;
        n = 16'h0000;
        p = {fin1, fin0, t0, t1};
        while (p[s] !== 1'b1 && n < 16'h00C8) begin
            @(posedge clk);
            #10;
            p = {fin1, fin0, t0, t1};
            n++;
        end
        n = 16'h0000;
        do begin
            @(posedge clk);
            #10;
            p = {fin1, fin0, t0, t1};
            n++;
        end while (p[s] !== 1'b1 && n < 16'h00C8);
        check("pulse spacing", n, exp);
    endtask
    // one settle run: reference ticks counted while settling
    task automatic settle(input logic [1:0] ch, input logic [15:0] exp, input logic e);
        logic [15:0] n;
        n = 16'h0000;
        sel = ch;
        start = 1'b1;
        @(posedge clk);
        #10;
        start = 1'b0;
        check("active channel", {14'h0, act}, {14'h0, ch});
        // two-channel variant refuses channel 3 and stays idle
        if (ch == 2'h3) check("narrow refused", {15'h0, settling_n}, 16'h0000);
        while (conv !== 1'b1 && n < 16'h07D0) begin
            if (settling === 1'b1 && (ch == 2'h0 ? t0 : t1) === 1'b1) n++;
            @(posedge clk);
            #10;
        end
        check("settle ticks", n, exp);
        check("amplitude error", {15'h0, err}, {15'h0, e});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #10;
        rst = 1'b0;
        for (int a = 8'h11; a <= 8'h16; a++) begin
            host_u.rd(8'(a), v);
            check("reset value", v, 16'h0000);
        end
        settle(2'h1, 16'h0020, 1'b0);
        host_u.wr(8'h11, 16'h0001);
        host_u.wr(8'h12, 16'h0003);
        host_u.wr(8'h13, 16'hFFFF);
        host_u.wr(8'h14, 16'h2001);
        host_u.wr(8'h15, 16'h1003);
        host_u.wr(8'h16, 16'h5A5A);
        host_u.rd(8'h11, v);
        check("count ch1", v, 16'h0001);
        check("narrow ch1", rdata_n, 16'h0001);
        host_u.rd(8'h12, v);
        check("count ch2", v, 16'h0003);
        check("narrow ch2", rdata_n, 16'h0000);
        host_u.rd(8'h13, v);
        check("count ch3", v, 16'hFFFF);
        check("narrow ch3", rdata_n, 16'h0000);
        host_u.rd(8'h14, v);
        check("dividers ch0", v, 16'h2001);
        host_u.rd(8'h15, v);
        check("dividers ch1", v, 16'h1003);
        host_u.rd(8'h16, v);
        check("unmapped", v, 16'h0000);
        host_u.wr(8'h13, 16'h0002);
        gap(2, 16'h0008);
        gap(3, 16'h0004);
        gap(1, 16'h0001);
        gap(0, 16'h0003);
        settle(2'h0, 16'h0020, 1'b0);
        ok = 1'b0;
        en = 1'b1;
        settle(2'h1, 16'h0020, 1'b1);
        en = 1'b0;
        settle(2'h3, 16'h0020, 1'b0);
        ok = 1'b1;
        sel = 2'h1;
        start = 1'b1;
        @(posedge clk);
        #10;
        start = 1'b0;
        repeat (5) @(posedge clk);
        #10;
        settle(2'h2, 16'h0030, 1'b0);
        stop_test;
    end
endmodule
`default_nettype wire
